// File: hdl/touchpad_pen_extended_command_handler.sv
`timescale 1ns/10ps
module touchpad_pen_extended_command_handler
  import tp_cmd_pkg::*;
#(
  parameter int RECAL_CYCLES = RECAL_HOLD_CYC,
  parameter int SUPP_CYCLES = SUPP_CYC,
  parameter int STILL_CYCLES = STILL_CYC,
  parameter int FAST_CYCLES = FAST_CYC
)
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Command bytes from the link byte layer.
  input wire cmd_in_type i_cmd,
  output logic o_std_pass,
  // Reply bytes toward the link byte layer.
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_byte,
  input wire logic i_rsp_ready,
  // Sensing side.
  input wire pad_sample_type i_pad,
  input wire logic i_fast_motion,
  input wire logic i_pad_release,
  input wire logic i_pen_release,
  input wire key_event_type i_key,
  // Controls toward the packet builder and the analog front end.
  output pad_report_type o_pad,
  output logic o_release_req,
  output logic o_release_is_pen,
  input wire logic i_release_taken,
  output logic o_recal_start,
  output logic o_comm_hold,
  output logic o_pointing_halt,
  output logic o_report_enable,
  output logic o_advanced_mode,
  output logic o_tablet_select,
  output logic o_auto_recal_en,
  output logic o_suppress_en
);

  core_type s_q;
  core_type s_d;

  function automatic logic cmd_known(input logic [7:0] b);
    cmd_known = (b >= CMD_SEL_PAD && b <= CMD_SUPP_ON) || b == 8'hEE || b == 8'hF0 ||
                (b >= CMD_PREFIX_A && b <= 8'hF6) || b == RSP_RESEND || b == CMD_RESET;
  endfunction

  function automatic seq_state_type restart(input logic [7:0] b);
    if (b == CMD_PREFIX_A)
    begin
      restart = SQ_F2A;
    end
    else if (b == CMD_DISABLE)
    begin
      restart = SQ_F5A;
    end
    else
    begin
      restart = SQ_IDLE;
    end
  endfunction

  logic hold;
  logic take;
  logic bad;
  logic recal_req;
  logic key_edge;
  logic still_same;
  logic [7:0] b;
  logic [7:0] stat1;

  assign hold = (s_q.recal_cnt != '0);
  assign b = i_cmd.data;
  // Bytes that arrive during the hold are dropped; the link layer keeps the line busy then.
  assign take = i_cmd.valid && !hold;
  assign bad = take && !i_cmd.arg && !cmd_known(b);
  assign o_std_pass = take && !bad;
  assign key_edge = i_key.valid;
  assign still_same = i_pad.touch && i_pad.raw_x == s_q.last_x && i_pad.raw_y == s_q.last_y;

  always_comb
  begin
    stat1 = 8'h00;
    stat1[STAT_EN_BIT] = s_q.enabled;
    stat1[STAT_ADV_BIT] = s_q.advanced;
  end

  always_comb
  begin
    s_d = s_q;
    recal_req = 1'b0;
    s_d.recal_go = 1'b0;

    // Reply stream: error codes and the three status bytes.
    if (s_q.rsp_valid && i_rsp_ready)
    begin
      if (s_q.stat_left == 2'h2)
      begin
        s_d.rsp_byte = STAT_DONT_CARE;
        s_d.stat_left = 2'h1;
      end
      else if (s_q.stat_left == 2'h1)
      begin
        s_d.rsp_byte = s_q.tablet_sel ? SEL_TABLET_ONLY : SEL_PAD_ONLY;
        s_d.stat_left = 2'h0;
      end
      else
      begin
        s_d.rsp_valid = 1'b0;
      end
    end

    if (bad)
    begin
      s_d.seq = SQ_IDLE;
      s_d.f5_run = 3'h0;
      s_d.last_bad = 1'b1;
      // A reply still waiting is replaced; the host only cares about the newest error.
      s_d.rsp_valid = 1'b1;
      s_d.stat_left = 2'h0;
      s_d.rsp_byte = s_q.last_bad ? RSP_ERROR : RSP_RESEND;
    end
    else if (take && i_cmd.arg)
    begin
      s_d.seq = SQ_IDLE;
      s_d.f5_run = 3'h0;
      s_d.last_bad = 1'b0;
    end
    else if (take)
    begin
      s_d.last_bad = 1'b0;
      if (b == CMD_DISABLE)
      begin
        s_d.enabled = 1'b0;
        s_d.f5_run = (s_q.f5_run == ADV_F5_RUN) ? ADV_F5_RUN : s_q.f5_run + 3'h1;
        if (s_q.f5_run == ADV_F5_RUN - 3'h1)
        begin
          s_d.advanced = 1'b1;
        end
      end
      else
      begin
        s_d.f5_run = 3'h0;
      end
      if (b == CMD_ENABLE)
      begin
        s_d.enabled = 1'b1;
      end
      if (b == CMD_RESET)
      begin
        s_d.advanced = 1'b0;
      end

      s_d.seq = restart(b);
      case (s_q.seq)
        SQ_F2A:
        begin
          if (b == CMD_PREFIX_A)
          begin
            s_d.seq = SQ_F2B;
          end
        end
        SQ_F2B:
        begin
          if (b == CMD_PREFIX_A)
          begin
            s_d.seq = SQ_F2C;
          end
        end
        SQ_F2C:
        begin
          if (b == CMD_STATUS)
          begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_byte = stat1;
            s_d.stat_left = STAT_BYTES - 2'h1;
          end
          else if (b == CMD_SEL_PAD)
          begin
            s_d.tablet_sel = 1'b0;
          end
          else if (b == CMD_SEL_PEN)
          begin
            s_d.tablet_sel = 1'b1;
          end
        end
        SQ_F5A:
        begin
          if (b == CMD_DISABLE)
          begin
            s_d.seq = SQ_F5B;
          end
        end
        SQ_F5B:
        begin
          if (b == CMD_SEL_PAD || b == CMD_SEL_PEN || b == CMD_AUTO_OFF || b == CMD_SUPP_ON)
          begin
            s_d.seq = SQ_F5OP;
            s_d.op = b;
          end
          else if (b == CMD_DISABLE)
          begin
            s_d.seq = SQ_F5B;
          end
        end
        SQ_F5OP:
        begin
          if (b == CMD_DISABLE)
          begin
            s_d.seq = SQ_IDLE;
            s_d.enabled = 1'b0;
            if (s_q.op == CMD_SEL_PAD)
            begin
              recal_req = 1'b1;
            end
            else if (s_q.op == CMD_SEL_PEN)
            begin
              s_d.auto_en = 1'b1;
            end
            else if (s_q.op == CMD_AUTO_OFF)
            begin
              s_d.auto_en = 1'b0;
            end
            else
            begin
              s_d.supp_en = 1'b1;
            end
          end
        end
        default:
        begin
        end
      endcase
    end

    // Key chord: three keys held in any order, then the last key pressed.
    if (i_key.valid)
    begin
      if (i_key.code == KEY_CHORD_A)
      begin
        s_d.held[0] = i_key.make;
      end
      if (i_key.code == KEY_CHORD_B)
      begin
        s_d.held[1] = i_key.make;
      end
      if (i_key.code == KEY_CHORD_C)
      begin
        s_d.held[2] = i_key.make;
      end
      if (i_key.code == KEY_CHORD_LAST && i_key.make && &s_q.held && !hold)
      begin
        recal_req = 1'b1;
      end
    end

    // Automatic recalibration watchers.
    // Watchers stop at full scale, so a long run cannot wrap round and hide the trigger.
    if (!i_fast_motion)
    begin
      s_d.fast_cnt = '0;
    end
    else if (s_q.fast_cnt != '1)
    begin
      s_d.fast_cnt = s_q.fast_cnt + FAST_W'(1);
    end
    if (!still_same)
    begin
      s_d.still_cnt = '0;
    end
    else if (s_q.still_cnt != '1)
    begin
      s_d.still_cnt = s_q.still_cnt + STILL_W'(1);
    end
    s_d.last_x = i_pad.raw_x;
    s_d.last_y = i_pad.raw_y;
    if (s_q.auto_en && !hold &&
        (s_q.fast_cnt >= FAST_W'(FAST_CYCLES) || s_q.still_cnt >= STILL_W'(STILL_CYCLES)))
    begin
      recal_req = 1'b1;
      s_d.fast_cnt = '0;
      s_d.still_cnt = '0;
    end

    if (hold)
    begin
      s_d.recal_cnt = s_q.recal_cnt - RECAL_W'(1);
    end
    if (recal_req)
    begin
      s_d.recal_go = 1'b1;
      s_d.recal_cnt = RECAL_W'(RECAL_CYCLES);
      s_d.enabled = 1'b0;
    end

    // Typing suppression restarts on every press or release, never on a held key.
    if (s_q.supp_cnt != '0)
    begin
      s_d.supp_cnt = s_q.supp_cnt - SUPP_W'(1);
    end
    if (s_q.supp_en && key_edge)
    begin
      s_d.supp_cnt = SUPP_W'(SUPP_CYCLES);
    end

    // Release packets: a new release wins over a taken one in the same cycle.
    if (i_release_taken && s_q.rel_left != 2'h0)
    begin
      s_d.rel_left = s_q.rel_left - 2'h1;
    end
    if (i_pad_release || i_pen_release)
    begin
      s_d.rel_left = RELEASE_REPEAT;
      s_d.rel_pen = i_pen_release;
    end

    // Pad coordinates are blanked outside the active area or while pointing is halted.
    s_d.pad.valid = i_pad.touch && i_pad.in_area && s_q.enabled && s_q.supp_cnt == '0;
    s_d.pad.x = {1'b0, i_pad.raw_x} + PAD_X_OFFSET;
    s_d.pad.y = i_pad.raw_y;
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_rsp_valid = s_q.rsp_valid;
  assign o_rsp_byte = s_q.rsp_byte;
  assign o_pad = s_q.pad;
  assign o_release_req = (s_q.rel_left != 2'h0);
  assign o_release_is_pen = s_q.rel_pen;
  assign o_recal_start = s_q.recal_go;
  assign o_comm_hold = hold;
  assign o_pointing_halt = (s_q.supp_cnt != '0);
  assign o_report_enable = s_q.enabled;
  assign o_advanced_mode = s_q.advanced;
  assign o_tablet_select = s_q.tablet_sel;
  assign o_auto_recal_en = s_q.auto_en;
  assign o_suppress_en = s_q.supp_en;

endmodule // touchpad_pen_extended_command_handler

// File: hdl/tp_cmd_pkg.sv
// Function
// - Sequence F2 F2 F2 E9 answers with a status report of exactly three bytes.
// - Status byte 3 is 14 tablet only or 28 pad only; byte 1 holds enable and mode.
// - Sequence F5 F5 E6 F5 recalibrates the pad baseline as at power-up.
// - Host communication is held off about 150 ms during a recalibration.
// - After recalibration the device stays disabled until the enable command F4.
// - Keys 110, 129 and 89 held in any order, then key 59, start recalibration.
// - F5 F5 E7 F5 enables auto recalibration, F5 F5 EA F5 disables it; both disable.
// - With auto recalibration on, sustained fast motion or ten seconds still recalibrate.
// - F5 F5 EC F5 enables typing suppression and leaves the device disabled.
// - With suppression on, any key transition halts pad and pen for one second.
// - Each new transition extends the halt; a key merely held does not.
// - When a pad or pen touch ends, the release packet is sent twice.
// - Reported pad X is the raw position plus 300.
// - An invalid command byte is answered with FE.
// - A second invalid byte right after an invalid one is answered with FC.
// - Pad coordinates are sent only while a finger touches inside the active area.
// - Four consecutive F5 bytes select advanced reporting mode.
// - Reset or an FF command returns to plain mouse reporting mode.
package tp_cmd_pkg;

  localparam logic [7:0] CMD_SEL_PAD = 8'hE6;
  localparam logic [7:0] CMD_SEL_PEN = 8'hE7;
  localparam logic [7:0] CMD_PRIO = 8'hE8;
  localparam logic [7:0] CMD_STATUS = 8'hE9;
  localparam logic [7:0] CMD_AUTO_OFF = 8'hEA;
  localparam logic [7:0] CMD_SUPP_ON = 8'hEC;
  localparam logic [7:0] CMD_PREFIX_A = 8'hF2;
  localparam logic [7:0] CMD_ENABLE = 8'hF4;
  localparam logic [7:0] CMD_DISABLE = 8'hF5;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] RSP_RESEND = 8'hFE;
  localparam logic [7:0] RSP_ERROR = 8'hFC;
  localparam logic [7:0] SEL_TABLET_ONLY = 8'h14;
  localparam logic [7:0] SEL_PAD_ONLY = 8'h28;
  localparam logic [7:0] STAT_DONT_CARE = 8'h00;
  localparam int STAT_EN_BIT = 5;
  localparam int STAT_ADV_BIT = 4;
  localparam logic [1:0] STAT_BYTES = 2'h3;
  localparam logic [2:0] ADV_F5_RUN = 3'h4;
  localparam logic [1:0] RELEASE_REPEAT = 2'h2;
  localparam logic [7:0] KEY_CHORD_A = 8'h6E;
  localparam logic [7:0] KEY_CHORD_B = 8'h81;
  localparam logic [7:0] KEY_CHORD_C = 8'h59;
  localparam logic [7:0] KEY_CHORD_LAST = 8'h3B;
  localparam logic [10:0] PAD_X_OFFSET = 11'h12C;

  localparam int CLK_HZ = 10_000_000;
  localparam int RECAL_HOLD_MS = 150;
  localparam int SUPP_TIME_MS = 1000;
  localparam int STILL_TIME_S = 10;
  localparam int FAST_TIME_MS = 100;
  localparam int RECAL_HOLD_CYC = RECAL_HOLD_MS * (CLK_HZ / 1000);
  localparam int SUPP_CYC = SUPP_TIME_MS * (CLK_HZ / 1000);
  localparam int STILL_CYC = STILL_TIME_S * CLK_HZ;
  localparam int FAST_CYC = FAST_TIME_MS * (CLK_HZ / 1000);
  localparam int RECAL_W = 21;
  localparam int SUPP_W = 24;
  localparam int STILL_W = 27;
  localparam int FAST_W = 20;

  typedef enum logic [2:0] {SQ_IDLE, SQ_F2A, SQ_F2B, SQ_F2C, SQ_F5A, SQ_F5B, SQ_F5OP} seq_state_type;

  typedef struct packed {
    logic valid;
    logic arg;
    logic [7:0] data;
  } cmd_in_type;

  typedef struct packed {
    logic valid;
    logic make;
    logic [7:0] code;
  } key_event_type;

  typedef struct packed {
    logic touch;
    logic in_area;
    logic [9:0] raw_x;
    logic [9:0] raw_y;
  } pad_sample_type;

  typedef struct packed {
    logic valid;
    logic [10:0] x;
    logic [9:0] y;
  } pad_report_type;

  typedef struct packed {
    seq_state_type seq;
    logic [7:0] op;
    logic [2:0] f5_run;
    logic enabled;
    logic advanced;
    logic tablet_sel;
    logic auto_en;
    logic supp_en;
    logic last_bad;
    logic rsp_valid;
    logic [7:0] rsp_byte;
    logic [1:0] stat_left;
    logic [RECAL_W-1:0] recal_cnt;
    logic recal_go;
    logic [SUPP_W-1:0] supp_cnt;
    logic [STILL_W-1:0] still_cnt;
    logic [FAST_W-1:0] fast_cnt;
    logic [2:0] held;
    logic [1:0] rel_left;
    logic rel_pen;
    logic [9:0] last_x;
    logic [9:0] last_y;
    pad_report_type pad;
  } core_type;

endpackage

// File: sim/tp_cmd_checker.sv
`timescale 1ns/10ps
module tp_cmd_checker
  import tp_cmd_pkg::*;
#(
  parameter int RECAL_CYCLES = RECAL_HOLD_CYC
)
(
  // Clock, reset and inputs.
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire cmd_in_type i_cmd,
  input wire pad_sample_type i_pad,
  input wire logic i_pad_release,
  input wire key_event_type i_key,
  // Outputs of the handler.
  input wire logic o_std_pass,
  input wire logic o_rsp_valid,
  input wire logic [7:0] o_rsp_byte,
  input wire pad_report_type o_pad,
  input wire logic o_release_req,
  input wire logic o_recal_start,
  input wire logic o_comm_hold,
  input wire logic o_pointing_halt,
  input wire logic o_report_enable,
  input wire logic o_suppress_en
);
  logic [31:0] hold_n_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // The hold length is counted here because a repetition that long would not unroll.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst) hold_n_q <= 32'h0;
    else hold_n_q <= o_comm_hold ? hold_n_q + 32'h1 : 32'h0;
  recal_hold_a: assert property (o_recal_start |-> o_comm_hold && !o_report_enable ##1 !o_recal_start)
    else $error("recal start without hold");
  hold_len_a: assert property ($fell(o_comm_hold) |-> hold_n_q + 1 >= RECAL_CYCLES && hold_n_q <= RECAL_CYCLES + 1)
    else $error("hold length wrong");
  hold_max_a: assert property (o_comm_hold |-> hold_n_q <= RECAL_CYCLES)
    else $error("hold too long");
  hold_refuse_a: assert property (o_comm_hold |-> !o_std_pass)
    else $error("byte taken during hold");
  pad_offset_a: assert property (o_pad.valid |-> o_pad.x == {1'b0, $past(i_pad.raw_x)} + PAD_X_OFFSET)
    else $error("pad x offset wrong");
  pad_area_a: assert property (o_pad.valid |-> $past(i_pad.touch && i_pad.in_area))
    else $error("pad data outside touch");
  halt_gate_a: assert property (o_pointing_halt && $past(o_pointing_halt) |-> !o_pad.valid)
    else $error("pad data while halted");
  key_halt_a: assert property (i_key.valid && o_suppress_en |=> o_pointing_halt)
    else $error("key did not halt");
  bad_reply_a: assert property (i_cmd.valid && !i_cmd.arg && !o_comm_hold && !o_std_pass
    |=> o_rsp_valid && (o_rsp_byte == RSP_RESEND || o_rsp_byte == RSP_ERROR))
    else $error("invalid byte not answered");
  release_req_a: assert property (i_pad_release |=> o_release_req)
    else $error("release not requested");
  enable_set_a: assert property (o_std_pass && i_cmd.data == CMD_ENABLE |=> o_report_enable)
    else $error("enable not set");
  disable_clear_a: assert property (o_std_pass && i_cmd.data == CMD_DISABLE |=> !o_report_enable)
    else $error("disable not cleared");
endmodule // tp_cmd_checker

// File: sim/ps2_host_model.sv
`timescale 1ns/10ps
module ps2_host_model
  import tp_cmd_pkg::*;
(
  // Clock and replies.
  input wire logic i_clk_sys,
  input wire logic i_std_pass,
  input wire logic i_rsp_valid,
  input wire logic [7:0] i_rsp_byte,
  // Requests.
  output cmd_in_type o_cmd,
  output logic o_rsp_ready
);
  logic slow = 1'b0;
  logic ack = 1'b0;
  logic [7:0] rxq [$];
  initial o_cmd = '0;
  initial o_rsp_ready = 1'b1;
  // A slow host drops ready every other cycle, so a reply must stand until taken.
  always @(negedge i_clk_sys) o_rsp_ready <= slow ? !o_rsp_ready : 1'b1;
  always @(posedge i_clk_sys) if (i_rsp_valid && o_rsp_ready) rxq.push_back(i_rsp_byte);
  task automatic send(input logic [7:0] b);
    @(negedge i_clk_sys);
    o_cmd = '{valid: 1'b1, arg: 1'b0, data: b};
    #1 ack = i_std_pass;
    @(negedge i_clk_sys);
    o_cmd = '0;
  endtask
endmodule // ps2_host_model

// File: sim/touchpad_pen_extended_command_handler_tb_top.sv
`timescale 1ns/10ps
module touchpad_pen_extended_command_handler_tb_top;
  import tp_cmd_pkg::*;
  localparam int R_CYC = 20;
  localparam int S_CYC = 30;
  localparam int T_CYC = 40;
  localparam int F_CYC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fast = 1'b0;
  logic padrel = 1'b0;
  logic penrel = 1'b0;
  logic taken = 1'b0;
  pad_sample_type pad = '0;
  key_event_type key = '0;
  cmd_in_type cmd;
  pad_report_type prep;
  logic pass, rvld, rrdy, rreq, rpen, recal, hold, halt, ren, adv, tsel, aen, sen;
  logic [7:0] rbyte;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_recal = 0;
  touchpad_pen_extended_command_handler #(.RECAL_CYCLES(R_CYC), .SUPP_CYCLES(S_CYC), .STILL_CYCLES(T_CYC),
    .FAST_CYCLES(F_CYC)) u_touchpad_pen_extended_command_handler (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_cmd(cmd), .o_std_pass(pass), .o_rsp_valid(rvld), .o_rsp_byte(rbyte), .i_rsp_ready(rrdy), .i_pad(pad),
    .i_fast_motion(fast), .i_pad_release(padrel), .i_pen_release(penrel), .i_key(key), .o_pad(prep),
    .o_release_req(rreq), .o_release_is_pen(rpen), .i_release_taken(taken), .o_recal_start(recal),
    .o_comm_hold(hold), .o_pointing_halt(halt), .o_report_enable(ren), .o_advanced_mode(adv),
    .o_tablet_select(tsel), .o_auto_recal_en(aen), .o_suppress_en(sen));
  ps2_host_model u_ps2_host_model (.i_clk_sys(clk), .i_std_pass(pass), .i_rsp_valid(rvld), .i_rsp_byte(rbyte),
    .o_cmd(cmd), .o_rsp_ready(rrdy));
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (recal === 1'b1) n_recal <= n_recal + 1;
    if (cyc == 20000)
    begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkb(input string name, input logic exp, input logic got);
    chk(name, {15'h0, exp}, {15'h0, got});
  endtask
  task automatic seq4(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
    logic [7:0] s [4];
    s = '{a, b, c, d};
    foreach (s[i])
    begin
      u_ps2_host_model.send(s[i]);
      chkb("ack", 1'b1, u_ps2_host_model.ack);
    end
  endtask
  task automatic wait_hold();
    repeat (R_CYC + 10) if (hold === 1'b1) @(negedge clk);
    chkb("hold end", 1'b0, hold);
  endtask
  task automatic key_ev(input logic [7:0] c, input logic m);
    @(negedge clk);
    key = '{valid: 1'b1, make: m, code: c};
    @(negedge clk);
    key = '0;
  endtask
  task automatic t_status(input logic [7:0] e1, input logic [7:0] e3);
    seq4(CMD_PREFIX_A, CMD_PREFIX_A, CMD_PREFIX_A, CMD_STATUS);
    repeat (20) @(negedge clk);
    chk("count", 16'h0003, 16'(u_ps2_host_model.rxq.size()));
    chk("byte1", {8'h00, e1}, {8'h00, u_ps2_host_model.rxq[0]});
    chk("byte3", {8'h00, e3}, {8'h00, u_ps2_host_model.rxq[2]});
    u_ps2_host_model.rxq.delete();
  endtask
  task automatic t_modes();
    u_ps2_host_model.slow = 1'b1;
    t_status(8'h00, SEL_PAD_ONLY);
    u_ps2_host_model.send(CMD_ENABLE);
    t_status(8'h20, SEL_PAD_ONLY);
    seq4(CMD_DISABLE, CMD_DISABLE, CMD_DISABLE, CMD_DISABLE);
    t_status(8'h10, SEL_PAD_ONLY);
    u_ps2_host_model.send(CMD_ENABLE);
    seq4(CMD_PREFIX_A, CMD_PREFIX_A, CMD_PREFIX_A, CMD_SEL_PEN);
    t_status(8'h30, SEL_TABLET_ONLY);
    u_ps2_host_model.send(CMD_RESET);
    chkb("advanced", 1'b0, adv);
    seq4(CMD_PREFIX_A, CMD_PREFIX_A, CMD_PREFIX_A, CMD_SEL_PAD);
    chkb("tablet", 1'b0, tsel);
    u_ps2_host_model.slow = 1'b0;
    $display("test modes done");
  endtask
  task automatic t_error();
    logic [7:0] b [3];
    logic [7:0] e [3];
    b = '{8'h00, 8'h01, 8'h02};
    e = '{RSP_RESEND, RSP_ERROR, RSP_RESEND};
    foreach (b[i])
    begin
      if (i == 2) u_ps2_host_model.send(CMD_ENABLE);
      u_ps2_host_model.send(b[i]);
      chkb("bad ack", 1'b0, u_ps2_host_model.ack);
      repeat (3) @(negedge clk);
      chk("reply", {8'h00, e[i]}, {8'h00, u_ps2_host_model.rxq[i]});
    end
    u_ps2_host_model.rxq.delete();
    seq4(CMD_PREFIX_A, CMD_PREFIX_A, CMD_STATUS, CMD_STATUS);
    repeat (5) @(negedge clk);
    chk("no status", 16'h0000, 16'(u_ps2_host_model.rxq.size()));
    $display("test error done");
  endtask
  task automatic t_recal();
    int n0;
    n0 = n_recal;
    seq4(CMD_DISABLE, CMD_DISABLE, CMD_SEL_PAD, CMD_DISABLE);
    repeat (2) @(negedge clk);
    chk("recal", 16'h0001, 16'(n_recal - n0));
    chkb("hold", 1'b1, hold);
    u_ps2_host_model.send(CMD_ENABLE);
    chkb("held ack", 1'b0, u_ps2_host_model.ack);
    wait_hold();
    chkb("enable", 1'b0, ren);
    u_ps2_host_model.send(CMD_ENABLE);
    chkb("ack", 1'b1, u_ps2_host_model.ack);
    chkb("enable", 1'b1, ren);
    $display("test recal done");
  endtask
  task automatic t_pad();
    pad = '{touch: 1'b1, in_area: 1'b1, raw_x: 10'h3FF, raw_y: 10'h155};
    repeat (2) @(negedge clk);
    chkb("pad valid", 1'b1, prep.valid);
    chk("pad x", 16'h052B, {5'h00, prep.x});
    chk("pad y", 16'h0155, {6'h00, prep.y});
    pad.in_area = 1'b0;
    repeat (2) @(negedge clk);
    chkb("pad valid", 1'b0, prep.valid);
    pad = '0;
    for (int p = 0; p < 2; p++)
    begin
      @(negedge clk);
      padrel = (p == 0);
      penrel = (p == 1);
      @(negedge clk);
      padrel = 1'b0;
      penrel = 1'b0;
      chkb("pen", p == 1, rpen);
      for (int k = 0; k < 3; k++)
      begin
        chkb("release", k < 2, rreq);
        @(negedge clk);
        taken = 1'b1;
        @(negedge clk);
        taken = 1'b0;
      end
    end
    $display("test pad done");
  endtask
  task automatic t_chord();
    logic [7:0] kc [4];
    int n0;
    kc = '{KEY_CHORD_C, KEY_CHORD_A, KEY_CHORD_B, KEY_CHORD_LAST};
    n0 = n_recal;
    foreach (kc[i])
    begin
      chk("chord", 16'h0000, 16'(n_recal - n0));
      key_ev(kc[i], 1'b1);
    end
    repeat (2) @(negedge clk);
    chk("chord", 16'h0001, 16'(n_recal - n0));
    foreach (kc[i]) key_ev(kc[i], 1'b0);
    wait_hold();
    u_ps2_host_model.send(CMD_ENABLE);
    $display("test chord done");
  endtask
  task automatic t_auto();
    int n0;
    for (int m = 0; m < 2; m++)
    begin
      seq4(CMD_DISABLE, CMD_DISABLE, m == 0 ? CMD_SEL_PEN : CMD_AUTO_OFF, CMD_DISABLE);
      chkb("auto", m == 0, aen);
      chkb("enable", 1'b0, ren);
      u_ps2_host_model.send(CMD_ENABLE);
      n0 = n_recal;
      fast = 1'b1;
      repeat (F_CYC + 3) @(negedge clk);
      fast = 1'b0;
      chkb("fast", m == 0, n_recal > n0);
      wait_hold();
      n0 = n_recal;
      pad = '{touch: 1'b1, in_area: 1'b1, raw_x: 10'h0AA, raw_y: 10'h055};
      repeat (T_CYC + 5) @(negedge clk);
      pad = '0;
      chkb("still", m == 0, n_recal > n0);
      wait_hold();
    end
    u_ps2_host_model.send(CMD_ENABLE);
    $display("test auto done");
  endtask
  task automatic t_supp();
    seq4(CMD_DISABLE, CMD_DISABLE, CMD_SUPP_ON, CMD_DISABLE);
    chkb("supp", 1'b1, sen);
    chkb("enable", 1'b0, ren);
    u_ps2_host_model.send(CMD_ENABLE);
    pad = '{touch: 1'b1, in_area: 1'b1, raw_x: 10'h011, raw_y: 10'h022};
    key_ev(8'h10, 1'b1);
    @(negedge clk);
    chkb("halt", 1'b1, halt);
    chkb("pad valid", 1'b0, prep.valid);
    repeat (20) @(negedge clk);
    key_ev(8'h10, 1'b0);
    repeat (20) @(negedge clk);
    chkb("halt", 1'b1, halt);
    repeat (S_CYC + 5) @(negedge clk);
    chkb("halt", 1'b0, halt);
    chkb("pad valid", 1'b1, prep.valid);
    pad = '0;
    $display("test supp done");
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_modes();
    t_error();
    t_recal();
    t_pad();
    t_chord();
    t_auto();
    t_supp();
    end_of_test();
  end
endmodule // touchpad_pen_extended_command_handler_tb_top
bind touchpad_pen_extended_command_handler tp_cmd_checker #(.RECAL_CYCLES(RECAL_CYCLES)) u_tp_cmd_checker (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_cmd(i_cmd), .i_pad(i_pad), .i_pad_release(i_pad_release),
  .i_key(i_key), .o_std_pass(o_std_pass), .o_rsp_valid(o_rsp_valid), .o_rsp_byte(o_rsp_byte), .o_pad(o_pad),
  .o_release_req(o_release_req), .o_recal_start(o_recal_start), .o_comm_hold(o_comm_hold),
  .o_pointing_halt(o_pointing_halt), .o_report_enable(o_report_enable), .o_suppress_en(o_suppress_en));
